// ===== src/silod_top.sv
// serial-in shift register, strobed latches and gated outputs
`timescale 1ns/1ps
`include "silod_defines.svh"

module silod_top #(
  parameter int NBITS      = `SILOD_NBITS,
  parameter int FIFO_DEPTH = `SILOD_FIFO_DEPTH
) (
  input  wire logic             REF_CLK,
  input  wire logic             RESETN,
  input  wire logic             SER_IN,
  input  wire logic             SHIFT_CLK,
  input  wire logic             STROBE,
  input  wire logic             ENABLE,
  output logic                  SER_OUT,
  output logic [NBITS-1:0]      DRV_OUT,
  output logic                  SHIFT_READY
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  silod_pkg::silod_pins_t pins;
  silod_pkg::silod_pins_t sync1_reg;
  silod_pkg::silod_pins_t sync2_reg;
  logic                   clk_prev_reg;
  logic                   data_s;
  logic                   clk_s;
  logic                   strobe_s;
  logic                   enable_s;
  logic                   clk_rise;

  assign pins[`SILOD_SYNC_DATA] = SER_IN;
  assign pins[`SILOD_SYNC_CLK]  = SHIFT_CLK;
  assign pins[`SILOD_SYNC_STB]  = STROBE;
  assign pins[`SILOD_SYNC_EN]   = ENABLE;

  // first stage feeds only the second, guarding against metastability
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1_reg <= `SILOD_SYNC_RST;
    end else begin
      sync1_reg <= pins;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync2_reg <= `SILOD_SYNC_RST;
    end else begin
      sync2_reg <= sync1_reg;
    end
  end

  assign data_s   = sync2_reg[`SILOD_SYNC_DATA];
  assign clk_s    = sync2_reg[`SILOD_SYNC_CLK];
  assign strobe_s = sync2_reg[`SILOD_SYNC_STB];
  assign enable_s = sync2_reg[`SILOD_SYNC_EN];

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      clk_prev_reg <= `SILOD_RST_BIT;
    end else begin
      clk_prev_reg <= clk_s;
    end
  end

  // data and clock pass equal synchroniser depth, so the bit seen with
  // the edge is the level present at the host's rising edge
  assign clk_rise = clk_s && !clk_prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // bit buffer between edge capture and the shift register
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_data;
  logic shift_pop;
  logic drain_stall;
  logic strobe_prev_reg;

  silod_fifo #(
    .WIDTH (`SILOD_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (REF_CLK),
    .rst_n     (RESETN),
    .in_valid  (clk_rise),
    .in_ready  (fifo_in_ready),
    .in_data   (data_s),
    .out_valid (fifo_out_valid),
    .out_ready (!drain_stall),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      strobe_prev_reg <= `SILOD_RST_BIT;
    end else begin
      strobe_prev_reg <= strobe_s;
    end
  end

  // on the falling strobe the stages freeze one cycle, so the value the
  // latches close on is the one the host saw shifted in
  assign drain_stall = strobe_prev_reg && !strobe_s;
  assign shift_pop   = fifo_out_valid && !drain_stall;

  // the host cannot be stalled; a bit arriving while full is lost, so the
  // ready flag lets a careful host pace itself
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SHIFT_READY <= `SILOD_RST_BIT;
    end else begin
      SHIFT_READY <= fifo_in_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shift register, latches and outputs
  logic [NBITS-1:0] shift_reg;
  logic [NBITS-1:0] latch_reg;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      shift_reg[0] <= `SILOD_RST_BIT;
    end else if (shift_pop) begin
      shift_reg[0] <= fifo_out_data;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < NBITS; gi++) begin : g_stage
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          shift_reg[gi] <= `SILOD_RST_BIT;
        end else if (shift_pop) begin
          shift_reg[gi] <= shift_reg[gi-1];
        end
      end
    end
  endgenerate

  generate
    for (gi = 0; gi < NBITS; gi++) begin : g_bit
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          latch_reg[gi] <= `SILOD_RST_BIT;
        end else if (strobe_s) begin
          latch_reg[gi] <= shift_reg[gi];
        end
      end

      // enable only gates the driver, never the stored state
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          DRV_OUT[gi] <= `SILOD_OUT_OFF;
        end else if (enable_s) begin
          DRV_OUT[gi] <= `SILOD_OUT_OFF;
        end else begin
          DRV_OUT[gi] <= latch_reg[gi];
        end
      end
    end
  endgenerate

  // mirrors the last stage one cycle late, the same lag as a direct wire
  // through the output flop would add anyway
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      SER_OUT <= `SILOD_RST_BIT;
    end else begin
      SER_OUT <= shift_reg[NBITS-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_first_stage: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    shift_pop |=> shift_reg[0] == $past(fifo_out_data))
    else $error("stage one did not load the buffered bit");

  a_edge_reaches: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    clk_rise && fifo_in_ready |=> fifo_out_valid)
    else $error("captured bit missing from buffer");

  a_shift_advance: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    shift_pop |=> shift_reg[NBITS-1:1] == $past(shift_reg[NBITS-2:0]))
    else $error("stages did not advance by one");

  a_shift_still: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    !shift_pop |=> $stable(shift_reg))
    else $error("stages moved without a shift");

  a_latch_copy: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    strobe_s |=> latch_reg == $past(shift_reg))
    else $error("latch did not follow stage under strobe");

  a_latch_hold: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    !strobe_s ##1 !strobe_s |-> $stable(latch_reg))
    else $error("latch changed with strobe low");

  a_outputs_off: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    enable_s [*2] |-> DRV_OUT == '0 &&
      ($stable(latch_reg) || $past(strobe_s)))
    else $error("outputs on while enable high");

  a_output_follow: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    !enable_s |=> DRV_OUT == $past(latch_reg))
    else $error("output does not match latch");

  a_serial_tail: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    shift_pop |=> ##1 SER_OUT == $past(shift_reg[NBITS-1]))
    else $error("serial output lost the last stage");

  a_drain_bound: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    fifo_out_valid |-> ##[0:1] shift_pop)
    else $error("buffer not drained");

  // a captured edge reaches stage one within the drain stall allowance
  a_rise_to_shift: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    clk_rise && fifo_in_ready |-> ##[1:2] shift_pop)
    else $error("captured bit never shifted in");

  // one host edge must never shift twice
  a_edge_single: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    clk_rise |=> !clk_rise)
    else $error("edge detector fired twice");

  // at the legal host pace the buffer drains faster than it fills
  a_never_full: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    clk_rise |-> fifo_in_ready)
    else $error("bit arrived while buffer full");

  // pins reach the logic only through the second flop
  a_sync_depth: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    1'h1 |=> sync2_reg == $past(sync1_reg))
    else $error("pin synchroniser skipped a stage");

  // the stall lasts one cycle so the buffer cannot back up
  a_stall_once: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    drain_stall |=> !drain_stall)
    else $error("drain stall held too long");

  a_stall_freeze: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    $fell(strobe_s) |=> $stable(shift_reg))
    else $error("stages moved as the latches closed");

  a_enable_off: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    enable_s |=> DRV_OUT == '0)
    else $error("output on one cycle after enable high");

  a_output_on: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    !enable_s ##1 (!enable_s && $stable(latch_reg)) |-> DRV_OUT == latch_reg)
    else $error("enabled output differs from latch");

  // between shifts the cascade output settles on the last stage
  a_serial_mirror: assert property (
    @(posedge REF_CLK) disable iff (!RESETN)
    !shift_pop |=> SER_OUT == shift_reg[NBITS-1])
    else $error("serial output differs from last stage");

  c_strobe_pulse: cover property (@(posedge REF_CLK) disable iff (!RESETN)
    !strobe_s ##1 strobe_s [*3] ##1 !strobe_s);

  c_enable_cycle: cover property (@(posedge REF_CLK) disable iff (!RESETN)
    enable_s ##1 !enable_s ##1 DRV_OUT != '0);

  c_two_shifts: cover property (@(posedge REF_CLK) disable iff (!RESETN)
    shift_pop ##[1:15] shift_pop);

  // strobe tied high with outputs held off while shifting
  c_tied_shift: cover property (@(posedge REF_CLK) disable iff (!RESETN)
    strobe_s && enable_s && shift_pop);
endmodule

// ===== inc/silod_defines.svh
// constants shared by the serial-in latched output driver files
`ifndef SILOD_DEFINES_SVH
`define SILOD_DEFINES_SVH

`define SILOD_NBITS       8
`define SILOD_FIFO_WIDTH  1
`define SILOD_FIFO_DEPTH  16
`define SILOD_RST_BIT     1'h0
`define SILOD_OUT_OFF     1'h0
`define SILOD_SYNC_RST    4'h0
`define SILOD_SYNC_DATA   0
`define SILOD_SYNC_CLK    1
`define SILOD_SYNC_STB    2
`define SILOD_SYNC_EN     3

`endif

// ===== inc/silod_pkg.sv
// types shared by the serial-in latched output driver files
`include "silod_defines.svh"

package silod_pkg;
  typedef logic [`SILOD_NBITS-1:0] silod_word_t;
  typedef logic [3:0]              silod_pins_t;
endpackage

// ===== src/silod_fifo.sv
// first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
`include "silod_defines.svh"

module silod_fifo #(
  parameter int WIDTH = `SILOD_FIFO_WIDTH,
  parameter int DEPTH = `SILOD_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  localparam logic [AW-1:0] PTR_ONE  = AW'(1);
  localparam logic [AW:0]   CNT_ONE  = (AW + 1)'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != FULL_CNT);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + PTR_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + PTR_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + CNT_ONE;
    end else if (pop && !push) begin
      count_reg <= count_reg - CNT_ONE;
    end
  end

  // a push must never overwrite the head the reader is still looking at
  a_head_stable: assert property (@(posedge clk) disable iff (!rst_n)
    out_valid && !out_ready |=> $stable(out_data))
    else $error("buffer head changed while stalled");
endmodule

// ===== dv/silod_host.sv
// host-side model driving the data, shift clock, strobe and enable pins
`timescale 1ns/1ps

module silod_host (
  input  wire logic ref_clk,
  output logic      ser_in,
  output logic      shift_clk,
  output logic      strobe,
  output logic      enable
);
  initial begin
    ser_in = 1'h0;
    shift_clk = 1'h0;
    strobe = 1'h0;
    enable = 1'h0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // data is set up 3 cycles ahead and held until the clock falls
  task automatic shift_bit(input logic b);
    if (strobe) enable = 1'h1;
    ser_in = b;
    idle(3);
    shift_clk = 1'h1;
    idle(4);
    shift_clk = 1'h0;
    // a released data line must not keep looking valid
    ser_in = ~b;
    idle(4);
  endtask

  task automatic set_strobe(input logic v);
    strobe = v;
    idle(6);
  endtask

  task automatic set_enable(input logic v);
    enable = v;
    idle(6);
  endtask
endmodule

// ===== dv/silod_top_tb_top.sv
// self-checking bench for the serial-in latched output driver
`timescale 1ns/1ps

module silod_top_tb_top;
  logic                REF_CLK;
  logic                RESETN;
  wire logic           ser_in;
  wire logic           shift_clk;
  wire logic           strobe;
  wire logic           enable;
  logic                SER_OUT;
  logic [7:0]          DRV_OUT;
  logic                SHIFT_READY;
  silod_pkg::silod_word_t m_sreg;
  silod_pkg::silod_word_t m_latch;
  logic                m_en;
  logic                m_stb;
  int                  miscompares;
  int                  tests_run;
  integer              seed;
  logic [7:0]          b;

  silod_host i_silod_host (.ref_clk(REF_CLK), .ser_in(ser_in),
    .shift_clk(shift_clk), .strobe(strobe), .enable(enable));

  silod_top i_silod_top (.REF_CLK(REF_CLK), .RESETN(RESETN),
    .SER_IN(ser_in), .SHIFT_CLK(shift_clk), .STROBE(strobe),
    .ENABLE(enable), .SER_OUT(SER_OUT), .DRV_OUT(DRV_OUT),
    .SHIFT_READY(SHIFT_READY));

  initial begin
    REF_CLK = 1'h0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  task automatic print_verdict();
    $display("compares %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input silod_pkg::silod_word_t seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check_out();
    chk(DRV_OUT, m_en ? 8'h00 : m_latch);
    chk({7'h00, SER_OUT}, {7'h00, m_sreg[7]});
  endtask

  // first bit sent ends in stage eight
  task automatic send(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      i_silod_host.shift_bit(v[i]);
      m_sreg = {m_sreg[6:0], v[i]};
      if (m_stb) m_latch = m_sreg;
      check_out();
    end
  endtask

  task automatic strobe_to(input logic v);
    i_silod_host.set_strobe(v);
    m_stb = v;
    if (v) m_latch = m_sreg;
    check_out();
  endtask

  task automatic enable_to(input logic v);
    i_silod_host.set_enable(v);
    m_en = v;
    check_out();
  endtask

  // reset in mid-run clears stages, latches, buffer and outputs
  task automatic reset_mid();
    @(negedge REF_CLK);
    RESETN = 1'h0;
    m_sreg = 8'h00;
    m_latch = 8'h00;
    i_silod_host.idle(2);
    chk({7'h00, SHIFT_READY}, 8'h00);
    check_out();
    RESETN = 1'h1;
    i_silod_host.idle(4);
    chk({7'h00, SHIFT_READY}, 8'h01);
    check_out();
  endtask

  initial begin
    repeat (20000) @(posedge REF_CLK);
    miscompares++;
    print_verdict();
  end

  initial begin
    seed = 84;
    miscompares = 0;
    tests_run = 0;
    RESETN = 1'h0;
    m_sreg = 8'h00;
    m_latch = 8'h00;
    m_en = 1'h0;
    m_stb = 1'h0;
    repeat (2) @(negedge REF_CLK);
    RESETN = 1'h1;
    i_silod_host.idle(4);
    chk({7'h00, SHIFT_READY}, 8'h01);
    check_out();
    // latches hold while shifting, then take the byte on a strobe pulse
    repeat (3) begin
      b = 8'($random(seed));
      send(b);
      strobe_to(1'h1);
      strobe_to(1'h0);
    end
    // disabled outputs, latch and stages survive a shift underneath
    enable_to(1'h1);
    b = 8'($random(seed));
    send(b);
    enable_to(1'h0);
    strobe_to(1'h1);
    strobe_to(1'h0);
    // strobe tied high: latches follow the stages while enable is high
    enable_to(1'h1);
    strobe_to(1'h1);
    b = 8'($random(seed));
    send(b);
    enable_to(1'h0);
    strobe_to(1'h0);
    // mid-run reset, then the whole path must work again from clean state
    reset_mid();
    b = 8'($random(seed));
    send(b);
    strobe_to(1'h1);
    strobe_to(1'h0);
    print_verdict();
  end
endmodule
